// file: bench/ccr_host.sv
// Host model that issues secondary serial words to the register bank.
`timescale 1ns/10ps
`default_nettype none
module ccr_host (
  input wire logic clk,
  output logic word_stb,
  output ccr_pkg::ccr_word_t word_in,
  input wire logic reply_stb,
  input wire ccr_pkg::ccr_byte_t reply_data
);
  import ccr_pkg::*;
  logic got;
  ccr_byte_t last_q;
  initial begin
    word_stb = 1'b0;
    word_in = 16'h0000;
  end
  // Released word lines show the inverse so a stale word is never mistaken for a live one.
  task automatic xfer(input ccr_word_t w);
    @(posedge clk);
    #1;
    word_stb = 1'b1;
    word_in = w;
    @(posedge clk);
    #1;
    word_stb = 1'b0;
    word_in = ~w;
    got = reply_stb;
    last_q = reply_data;
  endtask
  task automatic acc(input logic rd, input logic [4:0] a, input ccr_byte_t d);
    xfer({2'b00, rd, a, d});
  endtask
endmodule // ccr_host
`default_nettype wire

// file: bench/tb_codec_control_register_bank.sv
// Self-checking bench for the codec control register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_codec_control_register_bank;
  import ccr_pkg::*;
  logic MCLK, NRST, WORD_STB, ADC_OVF, REPLY_STB, SW_RESET, POWER_DOWN;
  logic DIGITAL_LOOPBACK, ANALOG_LOOPBACK, MON_SRC_DATA_IN, SPEAKER_ON;
  ccr_word_t WORD_IN;
  ccr_byte_t REPLY_DATA, d, e;
  ccr_gain_t MON_GAIN, RX_GAIN, DAC_GAIN;
  int miscompares = 0;
  int checks_done = 0;
  ccr_byte_t mode_v[8] = '{8'h85, 8'h7A, 8'h06, 8'h07, 8'h03, 8'h01, 8'h04, 8'h00};
  ccr_byte_t gain_v[6] = '{8'h2B, 8'h93, 8'hFD, 8'h4C, 8'h65, 8'h00};
  ccr_bank dut (.MCLK(MCLK), .NRST(NRST), .WORD_STB(WORD_STB), .WORD_IN(WORD_IN),
    .ADC_OVF(ADC_OVF), .REPLY_STB(REPLY_STB), .REPLY_DATA(REPLY_DATA), .SW_RESET(SW_RESET),
    .POWER_DOWN(POWER_DOWN), .DIGITAL_LOOPBACK(DIGITAL_LOOPBACK),
    .ANALOG_LOOPBACK(ANALOG_LOOPBACK), .MON_SRC_DATA_IN(MON_SRC_DATA_IN),
    .MON_GAIN(MON_GAIN), .RX_GAIN(RX_GAIN), .DAC_GAIN(DAC_GAIN), .SPEAKER_ON(SPEAKER_ON));
  ccr_host h (.clk(MCLK), .word_stb(WORD_STB), .word_in(WORD_IN), .reply_stb(REPLY_STB),
    .reply_data(REPLY_DATA));
  task chk(input ccr_byte_t got, input ccr_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic ccr_gain_t cl(input ccr_gain_t g, input ccr_gain_t mx, input ccr_gain_t mu);
    return (g > mx) ? mu : g;
  endfunction
  task rd(input logic [4:0] a, input ccr_byte_t exp);
    h.acc(1'b1, a, 8'h00);
    chk({7'h00, h.got}, 8'h01);
    chk(h.last_q, exp);
  endtask
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  initial begin
    repeat (4000) @(posedge MCLK);
    miscompares++;
    summarize;
  end
  initial begin
    NRST = 1'b0;
    ADC_OVF = 1'b0;
    repeat (6) @(posedge MCLK);
    #1 NRST = 1'b1;
    repeat (3) @(posedge MCLK);
    rd(5'h01, 8'h00);
    rd(5'h02, 8'h00);
    foreach (mode_v[i]) begin
      d = mode_v[i];
      h.acc(1'b0, 5'h01, d);
      @(posedge MCLK);
      #1 e = {d[7:3], cl(d[2:0], 3'h5, 3'h0)};
      chk({SW_RESET, POWER_DOWN, DIGITAL_LOOPBACK, ANALOG_LOOPBACK, MON_SRC_DATA_IN, MON_GAIN}, e);
      rd(5'h01, d);
    end
    foreach (gain_v[i]) begin
      d = gain_v[i];
      h.acc(1'b0, 5'h02, d);
      @(posedge MCLK);
      #1 e = {cl(d[7:5], 3'h4, 3'h4), cl(d[4:2], 3'h4, 3'h4), d[1], 1'b0};
      chk({RX_GAIN, DAC_GAIN, SPEAKER_ON, 1'b0}, e);
      rd(5'h02, {d[7:1], 1'b0});
    end
    @(posedge MCLK);
    #1 ADC_OVF = 1'b1;
    @(posedge MCLK);
    #1 ADC_OVF = 1'b0;
    repeat (3) @(posedge MCLK);
    rd(5'h02, 8'h01);
    rd(5'h02, 8'h00);
    // An overflow that coincides with the clearing read keeps the flag set.
    @(posedge MCLK);
    #1 ADC_OVF = 1'b1;
    rd(5'h02, 8'h01);
    ADC_OVF = 1'b0;
    rd(5'h02, 8'h01);
    rd(5'h02, 8'h00);
    h.acc(1'b0, 5'h03, 8'hFF);
    h.acc(1'b0, 5'h00, 8'hFF);
    h.xfer(16'h81FF);
    rd(5'h01, 8'h00);
    rd(5'h02, 8'h00);
    // A nonzero mode value makes the unmapped reads below distinguishable.
    h.acc(1'b0, 5'h01, 8'h5A);
    rd(5'h1F, 8'h00);
    h.xfer(16'hE100);
    chk(h.last_q, 8'h00);
    chk({7'h00, h.got}, 8'h01);
    rd(5'h01, 8'h5A);
    h.acc(1'b0, 5'h02, 8'hFE);
    // A second reset in mid-run must bring both registers back to zero.
    NRST = 1'b0;
    repeat (6) @(posedge MCLK);
    #1 NRST = 1'b1;
    repeat (3) @(posedge MCLK);
    #1 chk({SW_RESET, POWER_DOWN, DIGITAL_LOOPBACK, ANALOG_LOOPBACK, MON_SRC_DATA_IN, MON_GAIN}, 8'h00);
    chk({RX_GAIN, DAC_GAIN, SPEAKER_ON, 1'b0}, 8'h00);
    rd(5'h01, 8'h00);
    rd(5'h02, 8'h00);
    summarize;
  end
endmodule // tb_codec_control_register_bank
`default_nettype wire

// file: design/ccr_bank.sv
// Codec control register bank driven by decoded secondary serial words.
`timescale 1ns/10ps
`default_nettype none
`include "ccr_cfg.svh"

// Functional notes
// RL1: Bits 12..8 address, bits 7..0 data.
// RL2: Bit 13 low writes, high reads.
// RL3: Host zeroes bits 15..14; addresses 1, 2.
// RL4: Both registers reset to all zeros.
// RL5: Mode bit 7 asserts software reset.
// RL6: Mode bit 6 enables power-down.
// RL7: Mode bit 5 selects digital loopback.
// RL8: Mode bit 4 selects analog loopback.
// RL9: Mode bit 3 picks monitor source.
// RL10: Mode bits 2..0 set monitor gain.
// RL11: Gain bits 7..5 set receive gain.
// RL12: Gain bits 4..2 set DAC attenuation.
// RL13: Gain bit 1 enables speaker driver.
// RL14: Gain bit 0 flags ADC overflow, read-only.
// RL15: Reads return content; unmapped reads zero.
// RL16: Undefined gain codes act as mute.
module ccr_bank (
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic WORD_STB,
  input wire ccr_pkg::ccr_word_t WORD_IN,
  input wire logic ADC_OVF,
  output logic REPLY_STB,
  output ccr_pkg::ccr_byte_t REPLY_DATA,
  output logic SW_RESET,
  output logic POWER_DOWN,
  output logic DIGITAL_LOOPBACK,
  output logic ANALOG_LOOPBACK,
  output logic MON_SRC_DATA_IN,
  output ccr_pkg::ccr_gain_t MON_GAIN,
  output ccr_pkg::ccr_gain_t RX_GAIN,
  output ccr_pkg::ccr_gain_t DAC_GAIN,
  output logic SPEAKER_ON
);
  import ccr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic rst_meta_r;
  logic rst_n;
  ccr_state_t st_r;
  ccr_state_t st_nxt;
  logic [4:0] addr;
  logic is_read;
  logic is_write;
  logic pad_ok;
  logic hit_mode;
  logic hit_gain;
  ccr_byte_t gain_full;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // RL1 word field split.
  assign addr = WORD_IN[`CCR_ADDR_HI:`CCR_ADDR_LO];
  // RL3 padding bits checked.
  // A word with nonzero padding is treated as unmapped so a misframed word cannot corrupt state.
  assign pad_ok = (WORD_IN[`CCR_PAD_HI:`CCR_PAD_LO] == 2'b00);
  // RL2 direction bit decode.
  assign is_read = WORD_STB & WORD_IN[`CCR_RW_POS];
  assign is_write = WORD_STB & ~WORD_IN[`CCR_RW_POS];
  assign hit_mode = pad_ok && (addr == `CCR_REG_MODE);
  assign hit_gain = pad_ok && (addr == `CCR_REG_GAIN);
  assign gain_full = {st_r.gain, st_r.ovf};

  always_comb begin
    st_nxt = st_r;
    st_nxt.reply_stb = is_read;
    // RL15 read reply mux.
    if (is_read && hit_mode) begin
      st_nxt.reply_data = st_r.mode;
    end else if (is_read && hit_gain) begin
      st_nxt.reply_data = gain_full;
    end else if (is_read) begin
      st_nxt.reply_data = 8'h00;
    end
    if (is_write && hit_mode) begin
      st_nxt.mode = WORD_IN[`CCR_DATA_HI:`CCR_DATA_LO];
    end else if (is_write && hit_gain) begin
      st_nxt.gain = WORD_IN[`CCR_DATA_HI:`CCR_OVF_BIT + 1];
    end
    // RL14 sticky overflow flag.
    // The flag clears on a read of the gain register, but an overflow in that cycle wins.
    st_nxt.ovf = ADC_OVF | (st_r.ovf & ~(is_read && hit_gain));
  end

  // RL4 zero after reset.
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign REPLY_STB = st_r.reply_stb;
  assign REPLY_DATA = st_r.reply_data;
  // RL5 software reset.
  assign SW_RESET = st_r.mode[`CCR_SWRST_BIT];
  // RL6 power-down enable.
  assign POWER_DOWN = st_r.mode[`CCR_PWDN_BIT];
  // RL7 digital loopback.
  assign DIGITAL_LOOPBACK = st_r.mode[`CCR_DLOOP_BIT];
  // RL8 analog loopback.
  assign ANALOG_LOOPBACK = st_r.mode[`CCR_ALOOP_BIT];
  // RL9 monitor source select.
  assign MON_SRC_DATA_IN = st_r.mode[`CCR_MONSRC_BIT];
  // RL13 speaker driver enable.
  assign SPEAKER_ON = gain_full[`CCR_SPK_BIT];

  // RL10 monitor gain field.
  ccr_gain_clamp #(.MAX_CODE(`CCR_MON_MAX), .MUTE_CODE(`CCR_MON_MUTE)) u_mon_gain (
    .clk(MCLK),
    .rst_n(rst_n),
    .code(st_r.mode[`CCR_MONGAIN_HI:`CCR_MONGAIN_LO]),
    .level(MON_GAIN)
  );
  // RL11 receive gain field.
  ccr_gain_clamp #(.MAX_CODE(`CCR_PGA_MAX), .MUTE_CODE(`CCR_PGA_MUTE)) u_rx_gain (
    .clk(MCLK),
    .rst_n(rst_n),
    .code(gain_full[`CCR_RXGAIN_HI:`CCR_RXGAIN_LO]),
    .level(RX_GAIN)
  );
  // RL12 DAC attenuation field.
  ccr_gain_clamp #(.MAX_CODE(`CCR_PGA_MAX), .MUTE_CODE(`CCR_PGA_MUTE)) u_dac_gain (
    .clk(MCLK),
    .rst_n(rst_n),
    .code(gain_full[`CCR_DACGAIN_HI:`CCR_DACGAIN_LO]),
    .level(DAC_GAIN)
  );

  ////////////////////////////////////////////////////////////////////////////////
  write_mode_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL2
    is_write && hit_mode |=> st_r.mode == $past(WORD_IN[7:0]))
    else $error("Mode register write lost.");
  write_gain_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL1
    is_write && hit_gain |=> st_r.gain == $past(WORD_IN[7:1]))
    else $error("Gain register write lost.");
  read_mode_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL15
    is_read && hit_mode |=> REPLY_STB && REPLY_DATA == $past(st_r.mode))
    else $error("Mode register read reply wrong.");
  unmapped_read_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL15
    is_read && !hit_mode && !hit_gain |=> REPLY_STB && REPLY_DATA == 8'h00)
    else $error("Unmapped read did not return zero.");
  no_reply_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL2
    !is_read |=> !REPLY_STB)
    else $error("Reply without read request.");
  // An overflow in the cycle of a clearing read must still leave the flag set.
  ovf_set_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL14
    ADC_OVF |=> st_r.ovf)
    else $error("Overflow flag not set.");
  ovf_clear_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL14
    is_read && hit_gain && !ADC_OVF |=> !st_r.ovf)
    else $error("Overflow flag not cleared by read.");
  swrst_out_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL5
    is_write && hit_mode && WORD_IN[7] |=> SW_RESET)
    else $error("Software reset not asserted after write.");
  reset_zero_a: assert property (@(posedge MCLK) // RL4
    $rose(rst_n) |-> st_r.mode == 8'h00 && st_r.gain == 7'h00)
    else $error("Registers not zero after reset.");
  mon_clamp_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL16
    st_r.mode[2:0] > 3'h5 |=> MON_GAIN == 3'h0)
    else $error("Undefined monitor gain not muted.");
  rx_clamp_a: assert property (@(posedge MCLK) disable iff (!rst_n) // RL11
    st_r.gain[6:4] > 3'h4 |=> RX_GAIN == 3'h4)
    else $error("Undefined receive gain not muted.");
endmodule // ccr_bank
`default_nettype wire

// file: design/ccr_gain_clamp.sv
// Registered gain code clamp that maps undefined codes onto the mute code.
`timescale 1ns/10ps
`default_nettype none
module ccr_gain_clamp #(
  parameter logic [2:0] MAX_CODE = 3'h4,
  parameter logic [2:0] MUTE_CODE = 3'h4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire ccr_pkg::ccr_gain_t code,
  output ccr_pkg::ccr_gain_t level
);
  import ccr_pkg::*;

  ccr_gain_t level_r;
  ccr_gain_t level_nxt;

  // RL16 undefined codes mute.
  always_comb begin
    level_nxt = (code > MAX_CODE) ? MUTE_CODE : code;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= 3'h0;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule // ccr_gain_clamp
`default_nettype wire

// file: shared/ccr_cfg.svh
// Offsets, field positions, reset values and gain codes of the codec control register bank.
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

`define CCR_REG_MODE 5'h01
`define CCR_REG_GAIN 5'h02
`define CCR_RESET_VAL 8'h00
`define CCR_PAD_HI 15
`define CCR_PAD_LO 14
`define CCR_RW_POS 13
`define CCR_ADDR_HI 12
`define CCR_ADDR_LO 8
`define CCR_DATA_HI 7
`define CCR_DATA_LO 0
`define CCR_SWRST_BIT 7
`define CCR_PWDN_BIT 6
`define CCR_DLOOP_BIT 5
`define CCR_ALOOP_BIT 4
`define CCR_MONSRC_BIT 3
`define CCR_MONGAIN_HI 2
`define CCR_MONGAIN_LO 0
`define CCR_RXGAIN_HI 7
`define CCR_RXGAIN_LO 5
`define CCR_DACGAIN_HI 4
`define CCR_DACGAIN_LO 2
`define CCR_SPK_BIT 1
`define CCR_OVF_BIT 0
`define CCR_MON_MAX 3'h5
`define CCR_MON_MUTE 3'h0
`define CCR_PGA_MAX 3'h4
`define CCR_PGA_MUTE 3'h4

`endif

// file: shared/ccr_pkg.sv
// Types shared by the codec control register bank modules.
package ccr_pkg;
  typedef logic [15:0] ccr_word_t;
  typedef logic [7:0] ccr_byte_t;
  typedef logic [2:0] ccr_gain_t;
  // Register state of the bank; the gain register keeps only its writable bits 7..1.
  typedef struct packed {
    ccr_byte_t mode;
    logic [6:0] gain;
    logic ovf;
    logic reply_stb;
    ccr_byte_t reply_data;
  } ccr_state_t;
endpackage
